/* File: timer3_pkg.sv */
// timer3 package: register offsets, field positions, reset values, source codes
// assumes an 8-bit io bus with 6-bit io addresses
package timer3_pkg;
    // ==========================================================
    // register offsets
    localparam logic [5:0] ADDR_TIMER_CONTROL = 6'h32;
    localparam logic [5:0] ADDR_TIMER_COUNT = 6'h33;
    localparam logic [5:0] ADDR_TIMER_PRESCALE = 6'h34;
    localparam logic [5:0] ADDR_TIMER_LIMIT = 6'h3F;
    // ==========================================================
    // field positions
    localparam int SRC_LSB = 4;
    localparam int OUTSEL_LSB = 2;
    localparam int MODE_BIT = 1;
    localparam int INV_BIT = 0;
    localparam int RES_BIT = 7;
    localparam int PRE_LSB = 5;
    // ==========================================================
    // reset values
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_PRESCALE = 8'h00;
    localparam logic [7:0] RST_LIMIT = 8'h00;
    localparam logic [5:0] RST_PRE_CNT = 6'h00;
    localparam logic [4:0] RST_SCL_CNT = 5'h00;
    // ==========================================================
    // clock source codes
    localparam logic [3:0] SRC_OFF = 4'h0;
    localparam logic [3:0] SRC_SYS = 4'h1;
    localparam logic [3:0] SRC_FAST_RC = 4'h2;
    localparam logic [3:0] SRC_EXT_OSC = 4'h3;
    localparam logic [3:0] SRC_SLOW_RC = 4'h4;
    localparam logic [3:0] SRC_CMP = 4'h5;
    localparam logic [3:0] SRC_PA0_RISE = 4'h8;
    localparam logic [3:0] SRC_PA0_FALL = 4'h9;
    // output route codes
    localparam logic [1:0] OUT_NONE = 2'h0;
    localparam logic [1:0] OUT_B5 = 2'h1;
    localparam logic [1:0] OUT_B6 = 2'h2;
    localparam logic [1:0] OUT_B7 = 2'h3;
endpackage : timer3_pkg

/* File: timer3_edge_sync.sv */
// timer3 edge sync: two-flop synchroniser plus rising edge detector for one line
// assumes input is asynchronous to clk_sys
`timescale 1ns/10ps
`default_nettype none
module timer3_edge_sync (
    input wire logic clk_sys, // system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic async_in, // asynchronous level
    output logic level, // synchronised level
    output logic rise // one-cycle pulse on rising edge
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } sync_state_t;
    sync_state_t st_ff;
    sync_state_t nxt_st;

    // ==========================================================
    // meta is read only by sync
    always_comb begin
        nxt_st = st_ff;
        nxt_st.meta = async_in;
        nxt_st.sync = st_ff.meta;
        nxt_st.prev = st_ff.sync;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign level = st_ff.sync;
    assign rise = st_ff.sync & ~st_ff.prev;
endmodule : timer3_edge_sync
`default_nettype wire

/* File: timer3_period_pwm.sv */
// timer3 period / pwm timer with io register port
// assumes a cpu io strobe interface on clk_sys; clock sources arrive asynchronous
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Control bits 7..4 pick the count source; 0000 stops it and 0001 uses the system clock.
// - Code 0010 uses the fast rc clock (or its doubled form), 0011 the external oscillator, 0100 the slow rc.
// - Code 0101 counts on the comparator result output.
// - Code 1000 counts on rising and 1001 on falling edges of port a line 0.
// - Control bits 3..2 route the output to none, port b line 5, 6 or 7.
// - Control bit 1 picks period mode when clear and pwm mode when set, resetting to zero.
// - Control bit 0 inverts the output polarity before it reaches the pin.
// - The counter register is 8-bit, readable and writable, and zero after reset.
// - The write-only prescale register holds resolution, a 1/4/16/64 prescaler and a 5-bit scaler.
module timer3_period_pwm #(
    parameter bit FAST_RC_DOUBLE = 1'b0, // timer_source_option
    parameter bit RESOLUTION_OPTION = 1'b0 // 0: 6-bit, 1: 7-bit when resolution bit set
) (
    input wire logic clk_sys, // system clock 100 MHz
    input wire logic rst, // synchronous reset
    input wire logic io_wr, // io write strobe
    input wire logic io_rd, // io read strobe
    input wire logic [5:0] io_addr, // io address
    input wire logic [7:0] io_wdata, // write data
    output logic [7:0] io_rdata, // registered read data
    input wire logic fast_internal_rc, // fast rc clock
    input wire logic fast_internal_rc_x2, // doubled fast rc clock
    input wire logic external_oscillator, // external oscillator
    input wire logic slow_internal_rc, // slow rc clock
    input wire logic cmp_result, // comparator result
    input wire logic port_a_line0, // port a line 0
    output logic port_b_line5, // timer output pin
    output logic port_b_line5_oe, // drive enable
    output logic port_b_line6, // timer output pin
    output logic port_b_line6_oe, // drive enable
    output logic port_b_line7, // timer output pin
    output logic port_b_line7_oe // drive enable
);
    typedef struct packed {
        logic [7:0] control;
        logic [7:0] count;
        logic [7:0] prescale;
        logic [7:0] limit;
        logic [5:0] pre_cnt;
        logic [4:0] scl_cnt;
        logic wave;
        logic pa0_prev;
        logic [7:0] rdata;
        logic [2:0] pin;
        logic [2:0] oe;
    } timer_state_t;
    timer_state_t st_ff;
    timer_state_t nxt_st;

    logic [5:0] sync_level;
    logic [5:0] sync_rise;
    logic [5:0] async_src;
    logic src_tick;
    logic pre_tick;
    logic scl_tick;
    logic [5:0] pre_div;
    logic [7:0] res_mask;
    logic out_level;
    logic [3:0] src;
    logic pa0_fall;

    // ==========================================================
    // synchronisers for every asynchronous source
    assign async_src = {port_a_line0, cmp_result, slow_internal_rc, external_oscillator,
                        fast_internal_rc_x2, fast_internal_rc};
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_sync
            timer3_edge_sync u_sync (
                .clk_sys(clk_sys),
                .rst(rst),
                .async_in(async_src[gi]),
                .level(sync_level[gi]),
                .rise(sync_rise[gi])
            );
        end
    endgenerate

    // per-source tick decode
    // every source but the system clock is an edge seen behind two flops,
    // so a tick lands about three cycles after the pin moves
    function automatic logic pick_tick(input logic [3:0] code, input logic [5:0] rise,
                                       input logic fall);
        case (code)
            timer3_pkg::SRC_SYS: pick_tick = 1'b1;
            timer3_pkg::SRC_FAST_RC: pick_tick = FAST_RC_DOUBLE ? rise[1] : rise[0];
            timer3_pkg::SRC_EXT_OSC: pick_tick = rise[2];
            timer3_pkg::SRC_SLOW_RC: pick_tick = rise[3];
            timer3_pkg::SRC_CMP: pick_tick = rise[4];
            timer3_pkg::SRC_PA0_RISE: pick_tick = rise[5];
            timer3_pkg::SRC_PA0_FALL: pick_tick = fall;
            default: pick_tick = 1'b0; // stopped or reserved
        endcase
    endfunction : pick_tick

    // falling edge of port a line 0 from the level kept in the state;
    // all inputs of the decode are arguments so the assign re-evaluates on each
    assign pa0_fall = st_ff.pa0_prev & ~sync_level[5];

    assign src = st_ff.control[timer3_pkg::SRC_LSB +: 4];
    assign src_tick = pick_tick(src, sync_rise, pa0_fall);

    // ==========================================================
    // prescaler divide 1/4/16/64 then scaler divide by value+1
    always_comb begin
        case (st_ff.prescale[timer3_pkg::PRE_LSB +: 2])
            2'h0: pre_div = 6'h00;
            2'h1: pre_div = 6'h03;
            2'h2: pre_div = 6'h0F;
            default: pre_div = 6'h3F;
        endcase
    end
    // a write to prescale clears both counters so a new ratio starts clean
    assign pre_tick = src_tick && (st_ff.pre_cnt >= pre_div);
    assign scl_tick = pre_tick && (st_ff.scl_cnt >= st_ff.prescale[4:0]);

    // resolution mask for pwm wrap
    // 6- or 7-bit width is a build choice; the field only enables it
    assign res_mask = !st_ff.prescale[timer3_pkg::RES_BIT] ? 8'hFF : (RESOLUTION_OPTION ? 8'h7F : 8'h3F);

    // output level with polarity
    assign out_level = st_ff.wave ^ st_ff.control[timer3_pkg::INV_BIT];

    // ==========================================================
    // next-state logic
    always_comb begin
        nxt_st = st_ff;
        // last synced level of port a line 0, resets low like the idle pin
        nxt_st.pa0_prev = sync_level[5];
        // counter and prescalers
        if (src_tick) begin
            nxt_st.pre_cnt = pre_tick ? timer3_pkg::RST_PRE_CNT : st_ff.pre_cnt + 6'h01;
        end
        if (pre_tick) begin
            nxt_st.scl_cnt = scl_tick ? timer3_pkg::RST_SCL_CNT : st_ff.scl_cnt + 5'h01;
        end
        if (scl_tick) begin
            if (st_ff.control[timer3_pkg::MODE_BIT]) begin
                // pwm: high from wrap to limit match
                nxt_st.count = (st_ff.count + 8'h01) & res_mask;
                if (((st_ff.count + 8'h01) & res_mask) == 8'h00) begin
                    nxt_st.wave = 1'b1;
                end
                if (((st_ff.count + 8'h01) & res_mask) == (st_ff.limit & res_mask)) begin
                    nxt_st.wave = 1'b0;
                end
            end else begin
                // period: toggle and restart on limit match
                if (st_ff.count == st_ff.limit) begin
                    nxt_st.count = timer3_pkg::RST_COUNT;
                    nxt_st.wave = ~st_ff.wave;
                end else begin
                    nxt_st.count = st_ff.count + 8'h01;
                end
            end
        end
        // register writes take priority over counting
        if (io_wr) begin
            case (io_addr)
                timer3_pkg::ADDR_TIMER_CONTROL: nxt_st.control = io_wdata;
                timer3_pkg::ADDR_TIMER_COUNT: nxt_st.count = io_wdata;
                timer3_pkg::ADDR_TIMER_PRESCALE: begin
                    nxt_st.prescale = io_wdata;
                    nxt_st.pre_cnt = timer3_pkg::RST_PRE_CNT;
                    nxt_st.scl_cnt = timer3_pkg::RST_SCL_CNT;
                end
                timer3_pkg::ADDR_TIMER_LIMIT: nxt_st.limit = io_wdata;
                default: ;
            endcase
        end
        // reads have no side effect; write-only registers read zero
        if (io_rd) begin
            case (io_addr)
                timer3_pkg::ADDR_TIMER_CONTROL: nxt_st.rdata = st_ff.control;
                timer3_pkg::ADDR_TIMER_COUNT: nxt_st.rdata = st_ff.count;
                default: nxt_st.rdata = 8'h00;
            endcase
        end
        // pin routing
        // every pin carries the level; only the routed one is enabled
        nxt_st.pin = {3{out_level}};
        case (st_ff.control[timer3_pkg::OUTSEL_LSB +: 2])
            timer3_pkg::OUT_B5: nxt_st.oe = 3'h1;
            timer3_pkg::OUT_B6: nxt_st.oe = 3'h2;
            timer3_pkg::OUT_B7: nxt_st.oe = 3'h4;
            default: nxt_st.oe = 3'h0;
        endcase
    end

    // state register
    // fields without a named reset value fall back to zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.control <= timer3_pkg::RST_CONTROL;
            st_ff.count <= timer3_pkg::RST_COUNT;
            st_ff.prescale <= timer3_pkg::RST_PRESCALE;
            st_ff.limit <= timer3_pkg::RST_LIMIT;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign io_rdata = st_ff.rdata;
    assign port_b_line5 = st_ff.pin[0];
    assign port_b_line6 = st_ff.pin[1];
    assign port_b_line7 = st_ff.pin[2];
    assign port_b_line5_oe = st_ff.oe[0];
    assign port_b_line6_oe = st_ff.oe[1];
    assign port_b_line7_oe = st_ff.oe[2];
endmodule : timer3_period_pwm
`default_nettype wire

/* File: timer3_sva.sv */
// timer3 checker: port-level timing of the io port and the output pins
// assumes clk_sys with synchronous active-high rst, bound to timer3_period_pwm
`timescale 1ns/10ps
`default_nettype none
module timer3_sva (
    input wire logic clk_sys, // system clock
    input wire logic rst, // synchronous reset
    input wire logic io_wr, // write strobe
    input wire logic io_rd, // read strobe
    input wire logic [5:0] io_addr, // io address
    input wire logic [7:0] io_wdata, // write data
    input wire logic [7:0] io_rdata, // read data
    input wire logic port_b_line5, // pin level
    input wire logic port_b_line5_oe, // pin enable
    input wire logic port_b_line6, // pin level
    input wire logic port_b_line6_oe, // pin enable
    input wire logic port_b_line7, // pin level
    input wire logic port_b_line7_oe // pin enable
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ==========================================
    // decoded strobes
    wire logic [2:0] oe = {port_b_line7_oe, port_b_line6_oe, port_b_line5_oe};
    wire logic wr_c = io_wr && io_addr == timer3_pkg::ADDR_TIMER_CONTROL;
    wire logic rd_c = io_rd && !io_wr && io_addr == timer3_pkg::ADDR_TIMER_CONTROL;
    // route field to enable pattern
    function automatic logic [2:0] route_of(input logic [7:0] c);
        return (c[3:2] == 2'h0) ? 3'h0 : 3'h1 << (c[3:2] - 2'h1);
    endfunction : route_of
    sequence ctrl_write_idle;
        wr_c ##1 !io_wr;
    endsequence
    sequence ctrl_write_read;
        ctrl_write_idle ##1 rd_c;
    endsequence
    // ==========================================
    // properties
    a_reset_clears: assert property (disable iff (1'b0) rst |=> io_rdata == 8'h00 && oe == 3'h0)
        else $error("outputs not cleared by reset");
    a_oe_onehot: assert property ($onehot0(oe))
        else $error("more than one pin enabled");
    a_pins_same_level: assert property (port_b_line5 == port_b_line6 && port_b_line6 == port_b_line7)
        else $error("pin levels differ");
    a_rdata_holds: assert property (!io_rd |=> $stable(io_rdata))
        else $error("read data changed without a read");
    a_wo_read_zero: assert property (io_rd && io_addr != timer3_pkg::ADDR_TIMER_CONTROL
        && io_addr != timer3_pkg::ADDR_TIMER_COUNT |=> io_rdata == 8'h00)
        else $error("write-only or unmapped read not zero");
    a_ctrl_readback: assert property (ctrl_write_read |=> io_rdata == $past(io_wdata, 3))
        else $error("control read back differs");
    a_route_oe: assert property (ctrl_write_idle |=> oe == route_of($past(io_wdata, 2)))
        else $error("pin enable does not follow route");
    // the enable moves two edges after the write edge, so three quiet edges are needed
    a_oe_stable: assert property (!wr_c [*3] |-> $stable(oe))
        else $error("pin enable moved without control write");
endmodule : timer3_sva
bind timer3_period_pwm timer3_sva u_sva (.clk_sys(clk_sys), .rst(rst), .io_wr(io_wr), .io_rd(io_rd),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .port_b_line5(port_b_line5),
    .port_b_line5_oe(port_b_line5_oe), .port_b_line6(port_b_line6), .port_b_line6_oe(port_b_line6_oe),
    .port_b_line7(port_b_line7), .port_b_line7_oe(port_b_line7_oe));
`default_nettype wire

/* File: testbench.sv */
// timer3 testbench: drives the io port and clock inputs, judges pins and reads
// assumes timer3_pkg and timer3_period_pwm compiled first
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [5:0] io_addr = 6'h00;
    logic [7:0] io_wdata = 8'h00;
    logic [5:0] ins = 6'h00;
    logic [7:0] io_rdata;
    logic p5, p5_oe, p6, p6_oe, p7, p7_oe;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    timer3_period_pwm DUT (.clk_sys(clk_sys), .rst(rst), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .fast_internal_rc(ins[0]), .fast_internal_rc_x2(ins[1]),
        .external_oscillator(ins[2]), .slow_internal_rc(ins[3]), .cmp_result(ins[4]), .port_a_line0(ins[5]),
        .port_b_line5(p5), .port_b_line5_oe(p5_oe), .port_b_line6(p6), .port_b_line6_oe(p6_oe),
        .port_b_line7(p7), .port_b_line7_oe(p7_oe));
    // ==========================================
    // clock and hang guard
    initial forever #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end
    // ==========================================
    // shared tasks
    task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1 io_wr = 1'b1;
        io_addr = a;
        io_wdata = d;
        @(posedge clk_sys);
        #1 io_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        #1 io_rd = 1'b1;
        io_addr = a;
        @(posedge clk_sys);
        #1 io_rd = 1'b0;
        d = io_rdata;
    endtask : rd
    // ==========================================
    // scenarios
    task automatic t_reset_values();
        logic [5:0] addrs [5] = '{6'h32, 6'h33, 6'h34, 6'h3F, 6'h10};
        logic [7:0] d;
        foreach (addrs[i]) begin
            rd(addrs[i], d);
            chk("reset read", d, 8'h00);
        end
    endtask : t_reset_values
    task automatic t_route();
        logic [7:0] c, d;
        for (int s = 0; s < 4; s++) begin
            for (int v = 0; v < 2; v++) begin
                c = 8'(s * 4 + v);
                wr(6'h32, c);
                rd(6'h32, d);
                chk("control", d, c);
                chk("enables", {5'h00, p7_oe, p6_oe, p5_oe}, (s == 0) ? 8'h00 : 8'h01 << (s - 1));
                chk("pin level", {7'h00, p5}, 8'(v));
            end
        end
        wr(6'h32, 8'h02);
        rd(6'h32, d);
        chk("mode bit", d, 8'h02);
        wr(6'h32, 8'h00);
    endtask : t_route
    task automatic t_stop_and_load();
        logic [7:0] d;
        wr(6'h33, 8'h5A);
        rd(6'h33, d);
        chk("count load", d, 8'h5A);
        repeat (20) @(posedge clk_sys);
        rd(6'h33, d);
        chk("stopped count", d, 8'h5A);
    endtask : t_stop_and_load
    // reads 64 cycles apart on the system clock
    task automatic t_prescale();
        logic [7:0] pv [5] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h21};
        logic [7:0] ev [5] = '{8'd64, 8'd16, 8'd4, 8'd1, 8'd8};
        logic [7:0] a, b;
        wr(6'h3F, 8'hFF);
        wr(6'h32, 8'h10);
        foreach (pv[i]) begin
            wr(6'h34, pv[i]);
            rd(6'h33, a);
            repeat (62) @(posedge clk_sys);
            rd(6'h33, b);
            chk("ticks", b - a, ev[i]);
        end
    endtask : t_prescale
    // five pulses on each selectable source line
    task automatic t_sources();
        logic [3:0] codes [6] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9};
        int idx [6] = '{0, 2, 3, 4, 5, 5};
        logic [7:0] a, b;
        wr(6'h34, 8'h00);
        foreach (codes[i]) begin
            wr(6'h32, {codes[i], 4'h0});
            rd(6'h33, a);
            repeat (5) begin
                repeat (4) @(posedge clk_sys);
                #1 ins[idx[i]] = 1'b1;
                repeat (4) @(posedge clk_sys);
                #1 ins[idx[i]] = 1'b0;
            end
            repeat (6) @(posedge clk_sys);
            rd(6'h33, b);
            chk("source edges", b - a, 8'd5);
        end
    endtask : t_sources
    // counts cycles with the routed pin high over a window
    task automatic count_high(input int n, output logic [7:0] hi);
        int k;
        k = 0;
        repeat (n) begin
            @(posedge clk_sys);
            #1 if (p5 === 1'b1) k++;
        end
        hi = 8'(k);
    endtask : count_high
    // period toggle, pwm duty, inverted duty and 6-bit resolution on the pin
    task automatic t_pwm();
        logic [7:0] hi;
        wr(6'h34, 8'h00);
        wr(6'h3F, 8'h07);
        wr(6'h33, 8'h00);
        wr(6'h32, 8'h14);
        repeat (40) @(posedge clk_sys);
        count_high(256, hi);
        chk("period toggle", hi, 8'h80);
        wr(6'h3F, 8'h40);
        wr(6'h32, 8'h16);
        repeat (300) @(posedge clk_sys);
        count_high(256, hi);
        chk("pwm duty", hi, 8'h40);
        wr(6'h32, 8'h17);
        repeat (4) @(posedge clk_sys);
        count_high(256, hi);
        chk("inverted duty", hi, 8'hC0);
        wr(6'h3F, 8'h10);
        wr(6'h34, 8'h80);
        repeat (300) @(posedge clk_sys);
        count_high(128, hi);
        chk("narrow duty", hi, 8'h60); // inverted
        wr(6'h32, 8'h00);
    endtask : t_pwm
    // ==========================================
    // main sequence
    initial begin
        repeat (20) @(posedge clk_sys);
        #1 rst = 1'b0;
        t_reset_values();
        t_route();
        t_stop_and_load();
        t_prescale();
        t_sources();
        t_pwm();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
